// >>> design/adcc_defs.vh
// Register offsets, field positions, reset values and timing for adcc
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH
// Byte offsets on the AXI4-Lite bus
`define ADCC_OFS_MODE0   6'h00
`define ADCC_OFS_MODE1   6'h04
`define ADCC_OFS_MODE2   6'h08
`define ADCC_OFS_UPPER   6'h0c
`define ADCC_OFS_LOWER   6'h10
`define ADCC_OFS_CHSEL   6'h14
`define ADCC_OFS_RESULT  6'h18
`define ADCC_OFS_IFLAG   6'h1c
`define ADCC_OFS_IMASK   6'h20
`define ADCC_OFS_PRIOHI  6'h24
`define ADCC_OFS_PRIOLO  6'h28
`define ADCC_OFS_PMC     6'h2c
`define ADCC_OFS_PDIR    6'h30
`define ADCC_OFS_STATUS  6'h34
// Field positions
`define ADCC_M0_CTRL     7
`define ADCC_M0_CHMODE   6
`define ADCC_M0_CMPEN    0
`define ADCC_M1_ONESHOT  5
`define ADCC_M2_NEGREF   5
`define ADCC_M2_RCK      3
`define ADCC_M2_RES      0
`define ADCC_CH_ISS      7
// Reset values
`define ADCC_RST_UPPER   8'hff
`define ADCC_RST_LOWER   8'h00
`define ADCC_RST_MASK    8'hff
`define ADCC_RST_PRIO    8'hff
`define ADCC_RST_PORT    8'hff
// Timing: sample cycles per conversion, stabilisation wait in conv clocks
`define ADCC_CONV_TICKS  6'd22
`define ADCC_STAB_TICKS  6'd4
`endif

// >>> design/adcc_top.v
// A/D converter control registers, clock divider and conversion sequencer
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`include "adcc_defs.vh"

module adcc_top
(
  input  wire        clk,
  input  wire        srst,
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        hw_trigger,
  input  wire [9:0]  sample_data,
  output reg         sample_strobe,
  output reg  [4:0]  analog_channel,
  output reg         sel_temp_sensor,
  output reg         sel_internal_ref,
  output reg         sel_amplifier,
  output reg  [1:0]  pos_ref_src,
  output reg         neg_ref_ext,
  output reg         comparator_run,
  output reg         pin0_analog,
  output reg         pin0_out_buf_on,
  output reg         conversion_end_irq,
  output reg  [1:0]  conv_end_prio
);

  // Control registers
  reg [7:0]  mode0_reg;
  reg [7:0]  mode1_reg;
  reg [7:0]  mode2_reg;
  reg [7:0]  upper_reg;
  reg [7:0]  lower_reg;
  reg [7:0]  chsel_reg;
  reg [15:0] result_reg;
  reg        flag_reg;
  reg [7:0]  mask_reg;
  reg [7:0]  priohi_reg;
  reg [7:0]  priolo_reg;
  reg [3:0]  pmc_reg;
  reg [3:0]  pdir_reg;
  reg        bad_ref_reg;

  // Hardware trigger pin synchroniser
  reg        trig_s1_reg;
  reg        trig_s2_reg;
  reg        trig_s3_reg;

  // Sequencer
  localparam ST_IDLE = 2'd0;
  localparam ST_STAB = 2'd1;
  localparam ST_CONV = 2'd2;
  reg [1:0]  state_reg;
  reg [5:0]  tick_cnt_reg;
  reg [5:0]  div_cnt_reg;
  reg        div_tick_reg;
  reg        done_reg;
  reg        armed_reg;

  // AXI write holding
  reg        aw_held_reg;
  reg        w_held_reg;
  reg [5:0]  awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;

  wire       ctrl_on    = mode0_reg[`ADCC_M0_CTRL];
  wire [1:0] trig_mode  = mode1_reg[7:6];
  wire       hw_mode    = trig_mode[1];
  wire       hw_wait    = (trig_mode == 2'b11);
  wire       one_shot   = mode1_reg[`ADCC_M1_ONESHOT];
  wire [2:0] clk_sel    = mode0_reg[5:3];
  wire       eight_bit  = mode2_reg[`ADCC_M2_RES];
  wire       trig_edge  = trig_s2_reg & ~trig_s3_reg;
  wire       do_write   = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire       wr_sel_b0  = do_write & wstrb_reg[0];

  // Conversion clock divisor; prohibited codes fall back to the slowest
  reg [5:0]  div_limit;
  always @*
  begin
    case (clk_sel)
      3'b000:  div_limit = 6'd63;
      3'b001:  div_limit = 6'd31;
      3'b010:  div_limit = 6'd15;
      3'b100:  div_limit = 6'd5;
      default: div_limit = 6'd63;
    endcase
  end

  // Result truncated in 8-bit mode; upper bits hold the value, left aligned
  wire [9:0] conv_val  = eight_bit ? {sample_data[9:2], 2'b00} : sample_data;
  wire [7:0] cmp_val   = sample_data[9:2];
  wire       in_range  = (lower_reg <= cmp_val) && (cmp_val <= upper_reg);
  wire       raise_req = mode2_reg[`ADCC_M2_RCK] ? ~in_range : in_range;

  // Trigger synchroniser: first stage read only by the second
  always @(posedge clk)
  begin
    if (srst)
    begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
    end
    else
    begin
      trig_s1_reg <= hw_trigger;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end

  // Divider makes the conversion clock enable; held while idle
  always @(posedge clk)
  begin
    if (srst || state_reg == ST_IDLE)
    begin
      div_cnt_reg  <= 6'd0;
      div_tick_reg <= 1'b0;
    end
    else if (div_cnt_reg >= div_limit)
    begin
      div_cnt_reg  <= 6'd0;
      div_tick_reg <= 1'b1;
    end
    else
    begin
      div_cnt_reg  <= div_cnt_reg + 6'd1;
      div_tick_reg <= 1'b0;
    end
  end

  // Sequencer: idle, stabilisation wait, conversion
  always @(posedge clk)
  begin
    if (srst)
    begin
      state_reg     <= ST_IDLE;
      tick_cnt_reg  <= 6'd0;
      done_reg      <= 1'b0;
      armed_reg     <= 1'b1;
      sample_strobe <= 1'b0;
    end
    else
    begin
      done_reg      <= 1'b0;
      sample_strobe <= 1'b0;
      if (!ctrl_on)
      begin
        state_reg <= ST_IDLE;
        armed_reg <= 1'b1;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            // Software mode starts at once; hardware modes await the edge
            if (!hw_mode && armed_reg)
            begin
              state_reg    <= ST_CONV;
              tick_cnt_reg <= 6'd0;
              armed_reg    <= 1'b0;
            end
            else if (hw_mode && trig_edge)
            begin
              state_reg    <= hw_wait ? ST_STAB : ST_CONV;
              tick_cnt_reg <= 6'd0;
            end
          end
          ST_STAB:
          begin
            if (div_tick_reg)
            begin
              if (tick_cnt_reg == `ADCC_STAB_TICKS - 6'd1)
              begin
                state_reg    <= ST_CONV;
                tick_cnt_reg <= 6'd0;
              end
              else
                tick_cnt_reg <= tick_cnt_reg + 6'd1;
            end
          end
          ST_CONV:
          begin
            if (div_tick_reg)
            begin
              if (tick_cnt_reg == `ADCC_CONV_TICKS - 6'd1)
              begin
                sample_strobe <= 1'b1;
                done_reg      <= 1'b1;
                tick_cnt_reg  <= 6'd0;
                // Sequential software mode loops on the same channel
                if (!one_shot && !hw_mode)
                  state_reg <= ST_CONV;
                else
                  state_reg <= ST_IDLE;
              end
              else
                tick_cnt_reg <= tick_cnt_reg + 6'd1;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // AXI4-Lite write: address and data accepted in either order
  always @(posedge clk)
  begin
    if (srst)
    begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= 6'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg   <= 1'b1;
        awaddr_reg    <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wstrb_reg    <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        // Addresses above STATUS and the read-only RESULT answer SLVERR
        s_axi_bresp  <= (awaddr_reg > `ADCC_OFS_STATUS ||
                         awaddr_reg == `ADCC_OFS_RESULT) ? 2'b10 : 2'b00;
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register file; only byte lane 0 carries data
  always @(posedge clk)
  begin
    if (srst)
    begin
      mode0_reg   <= 8'h00;
      mode1_reg   <= 8'h00;
      mode2_reg   <= 8'h00;
      upper_reg   <= `ADCC_RST_UPPER;
      lower_reg   <= `ADCC_RST_LOWER;
      chsel_reg   <= 8'h00;
      mask_reg    <= `ADCC_RST_MASK;
      priohi_reg  <= `ADCC_RST_PRIO;
      priolo_reg  <= `ADCC_RST_PRIO;
      pmc_reg     <= 4'hf;
      pdir_reg    <= 4'hf;
      flag_reg    <= 1'b0;
      result_reg  <= 16'h0000;
      bad_ref_reg <= 1'b0;
    end
    else
    begin
      if (wr_sel_b0)
      begin
        case (awaddr_reg)
          `ADCC_OFS_MODE0:  mode0_reg  <= wdata_reg[7:0];
          `ADCC_OFS_MODE1:  mode1_reg  <= wdata_reg[7:0] & 8'he3;
          `ADCC_OFS_MODE2:
          begin
            mode2_reg <= wdata_reg[7:0] & 8'he9;
            // Record a reference change made without passing through 00
            if (mode2_reg[7:6] != 2'b00 &&
                wdata_reg[7:6] != 2'b00 &&
                wdata_reg[7:6] != mode2_reg[7:6])
              bad_ref_reg <= 1'b1;
          end
          `ADCC_OFS_UPPER:  upper_reg  <= wdata_reg[7:0];
          `ADCC_OFS_LOWER:  lower_reg  <= wdata_reg[7:0];
          `ADCC_OFS_CHSEL:  chsel_reg  <= wdata_reg[7:0] & 8'h9f;
          `ADCC_OFS_IMASK:  mask_reg   <= wdata_reg[7:0];
          `ADCC_OFS_PRIOHI: priohi_reg <= wdata_reg[7:0];
          `ADCC_OFS_PRIOLO: priolo_reg <= wdata_reg[7:0];
          `ADCC_OFS_PMC:    pmc_reg    <= wdata_reg[3:0];
          `ADCC_OFS_PDIR:   pdir_reg   <= wdata_reg[3:0];
          `ADCC_OFS_STATUS: bad_ref_reg <= bad_ref_reg & ~wdata_reg[0];
          default: ;
        endcase
      end
      // Conversion end: store result, set flag if the window compare asks; set beats a clear
      if (done_reg)
        result_reg <= {conv_val, 6'b00_0000};
      if (done_reg && raise_req)
        flag_reg <= 1'b1;
      else if (wr_sel_b0 && awaddr_reg == `ADCC_OFS_IFLAG)
        flag_reg <= wdata_reg[0];
    end
  end

  // AXI4-Lite read, one cycle after the address is taken
  reg [31:0] rd_mux;
  always @*
  begin
    case (s_axi_araddr)
      `ADCC_OFS_MODE0:  rd_mux = {24'h0, mode0_reg[7] | (state_reg != ST_IDLE),
                                  mode0_reg[6:0]};
      `ADCC_OFS_MODE1:  rd_mux = {24'h0, mode1_reg};
      `ADCC_OFS_MODE2:  rd_mux = {24'h0, mode2_reg};
      `ADCC_OFS_UPPER:  rd_mux = {24'h0, upper_reg};
      `ADCC_OFS_LOWER:  rd_mux = {24'h0, lower_reg};
      `ADCC_OFS_CHSEL:  rd_mux = {24'h0, chsel_reg};
      `ADCC_OFS_RESULT: rd_mux = {16'h0, result_reg};
      `ADCC_OFS_IFLAG:  rd_mux = {31'h0, flag_reg};
      `ADCC_OFS_IMASK:  rd_mux = {24'h0, mask_reg};
      `ADCC_OFS_PRIOHI: rd_mux = {24'h0, priohi_reg};
      `ADCC_OFS_PRIOLO: rd_mux = {24'h0, priolo_reg};
      `ADCC_OFS_PMC:    rd_mux = {24'h0, 4'hf, pmc_reg};
      `ADCC_OFS_PDIR:   rd_mux = {24'h0, 4'hf, pdir_reg};
      `ADCC_OFS_STATUS: rd_mux = {28'h0, state_reg, 1'b0, bad_ref_reg};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= (s_axi_araddr > `ADCC_OFS_STATUS) ? 2'b10 : 2'b00;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Analog front-end controls, all registered
  always @(posedge clk)
  begin
    if (srst)
    begin
      analog_channel     <= 5'd0;
      sel_temp_sensor    <= 1'b0;
      sel_internal_ref   <= 1'b0;
      sel_amplifier      <= 1'b0;
      pos_ref_src        <= 2'b00;
      neg_ref_ext        <= 1'b0;
      comparator_run     <= 1'b0;
      pin0_analog        <= 1'b1;
      pin0_out_buf_on    <= 1'b0;
      conversion_end_irq <= 1'b0;
      conv_end_prio      <= 2'b11;
    end
    else
    begin
      // Scan mode is not sequenced here; channel code passes unchanged
      analog_channel   <= chsel_reg[4:0];
      sel_temp_sensor  <= chsel_reg[`ADCC_CH_ISS] &&
                          chsel_reg[4:0] == 5'd0;
      sel_internal_ref <= chsel_reg[`ADCC_CH_ISS] &&
                          chsel_reg[4:0] == 5'd1;
      sel_amplifier    <= ~chsel_reg[`ADCC_CH_ISS] &&
                          chsel_reg[4:0] == 5'b10111;
      // Prohibited code 11 is passed as supply rail for safety
      pos_ref_src      <= (mode2_reg[7:6] == 2'b11) ? 2'b00
                          : mode2_reg[7:6];
      neg_ref_ext      <= mode2_reg[`ADCC_M2_NEGREF];
      comparator_run   <= mode0_reg[`ADCC_M0_CMPEN];
      pin0_analog      <= pmc_reg[0];
      pin0_out_buf_on  <= ~pdir_reg[0];
      conversion_end_irq <= flag_reg & ~mask_reg[0];
      conv_end_prio    <= {priohi_reg[0], priolo_reg[0]};
    end
  end

endmodule // adcc_top

// >>> sim/adcc_properties.sv
// Concurrent checks on the converter control block ports
module adcc_properties
(
  input wire        clk,
  input wire        srst,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [5:0]  s_axi_araddr,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        sample_strobe,
  input wire        conversion_end_irq
);
  // Cycles since the last strobe or write beat; saturates so it never wraps
  logic [2:0] since_reg;
  always_ff @(posedge clk)
    if (srst)
      since_reg <= 3'd7;
    else if (sample_strobe || (s_axi_wvalid && s_axi_wready))
      since_reg <= 3'd0;
    else if (since_reg != 3'd7)
      since_reg <= since_reg + 3'd1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // Read address accepted, and a quiet stretch after a conversion end
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence strobe_quiet;
    !sample_strobe [*8];
  endsequence

  chk_strobe_gap: assert property (sample_strobe |=> strobe_quiet)
    else $error("conversion end strobe repeated too soon");
  chk_irq_cause: assert property ($rose(conversion_end_irq) |-> since_reg < 3'd6)
    else $error("interrupt rose without conversion end or write");
  chk_read_ok: assert property (ar_taken ##0 s_axi_araddr <= 6'h34
    |=> s_axi_rvalid && s_axi_rresp == 2'b00)
    else $error("mapped read not answered okay");
  chk_read_err: assert property (ar_taken ##0 s_axi_araddr > 6'h34
    |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  chk_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  chk_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read channel ready while response pending");
endmodule // adcc_properties

// >>> sim/adcc_top_tb.sv
// Self-checking bench for the converter control block
`include "adcc_defs.vh"

module adcc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, srst = 1, hw_trigger = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [9:0]  sample_data = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, sample_strobe, sel_temp_sensor, sel_amplifier;
  wire         sel_internal_ref, neg_ref_ext, comparator_run, pin0_analog;
  wire         pin0_out_buf_on, conversion_end_irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp, pos_ref_src, conv_end_prio;
  wire [31:0]  s_axi_rdata;
  wire [4:0]   analog_channel;
  int          num_errors = 0, tests_run = 0, i, n, dv, lim;
  integer      seed = 32'h51892b28;
  logic [7:0]  up, lo, c, m0;
  logic [7:0]  codes [7] = '{8'h00, 8'h03, 8'h10, 8'h16, 8'h17, 8'h80,
                             8'h81};
  logic [2:0]  divs [4] = '{3'd0, 3'd1, 3'd2, 3'd4};
  logic        f;

  adcc_top dut_u (.*);

  initial forever #12.5 clk = ~clk;

  task finish_test;
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // A bounded wait that ran out ends the run
  task tmo;
    num_errors++;
    $display("MISMATCH wait_limit exp answer got none");
    finish_test;
  endtask

  // Address and data offered together; each dropped once taken
  task wr(input [5:0] a, input [7:0] v, input [1:0] er = 2'b00);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= {24'h0, v};
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    if (n == 100) tmo;
    chk($sformatf("bresp_%h", a), er, s_axi_bresp);
    s_axi_bready <= 0;
    @(posedge clk);
  endtask

  task rdc(input [5:0] a, input [31:0] e, input [1:0] er = 2'b00);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    if (n == 100) tmo;
    chk($sformatf("rresp_%h", a), er, s_axi_rresp);
    chk($sformatf("rdata_%h", a), e, s_axi_rdata);
    s_axi_rready <= 0;
    @(posedge clk);
  endtask

  // Clock division from the clock select code
  function int dvf(input [2:0] cs);
    case (cs)
      3'd1: return 32;
      3'd2: return 16;
      3'd4: return 6;
      default: return 64;
    endcase
  endfunction

  // Interrupt decision of the window compare on the top eight bits
  function logic flag_of(input [9:0] sd, input [7:0] u, input [7:0] l,
                         input rck);
    return rck ^ (l <= sd[9:2] && sd[9:2] <= u);
  endfunction

  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    rdc(`ADCC_OFS_UPPER, 32'hff);
    rdc(`ADCC_OFS_LOWER, 32'h00);
    rdc(`ADCC_OFS_IMASK, 32'hff);
    rdc(`ADCC_OFS_PRIOHI, 32'hff);
    rdc(`ADCC_OFS_PMC, 32'hff);
    chk("prio_rst", 2'b11, conv_end_prio);
    chk("analog_rst", 1, pin0_analog);
    // Refused accesses must leave everything alone
    wr(`ADCC_OFS_RESULT, 8'h55, 2'b10);
    wr(6'h3c, 8'h00, 2'b10);
    rdc(6'h38, 32'h0, 2'b10);
    for (i = 0; i < 3; i++)
    begin
      up = 8'($random(seed));
      wr(`ADCC_OFS_UPPER, up);
      rdc(`ADCC_OFS_UPPER, {24'h0, up});
    end
    for (i = 0; i < 4; i++)
    begin
      wr(`ADCC_OFS_PRIOHI, {7'h7f, i[1]});
      wr(`ADCC_OFS_PRIOLO, {7'h7f, i[0]});
      chk("prio", i[1:0], conv_end_prio);
    end
    // Ends with the pin set up for analog sampling
    for (i = 0; i < 2; i++)
    begin
      wr(`ADCC_OFS_PMC, {7'h0, i[0]});
      rdc(`ADCC_OFS_PMC, {28'hf, 3'h0, i[0]});
      chk("pin_analog", i[0], pin0_analog);
      wr(`ADCC_OFS_PDIR, {7'h0, i[0]});
      rdc(`ADCC_OFS_PDIR, {28'hf, 3'h0, i[0]});
      chk("pin_buf", !i[0], pin0_out_buf_on);
    end
    for (i = 0; i < 7; i++)
    begin
      c = codes[i];
      wr(`ADCC_OFS_CHSEL, c);
      if (!c[7]) chk("channel", c[4:0], analog_channel);
      chk("amp", c == 8'h17, sel_amplifier);
      chk("temp", c == 8'h80, sel_temp_sensor);
      chk("iref", c == 8'h81, sel_internal_ref);
    end
    wr(`ADCC_OFS_CHSEL, 8'h00);
    wr(`ADCC_OFS_MODE0, 8'h41);
    rdc(`ADCC_OFS_MODE0, 32'h41);
    chk("cmp_on", 1, comparator_run);
    wr(`ADCC_OFS_MODE0, 8'h00);
    chk("cmp_off", 0, comparator_run);
    wr(`ADCC_OFS_MODE2, 8'h40);
    chk("pos_pin", 2'b01, pos_ref_src);
    wr(`ADCC_OFS_MODE2, 8'h00);
    wr(`ADCC_OFS_MODE2, 8'ha0);
    chk("pos_int", 2'b10, pos_ref_src);
    chk("neg_ext", 1, neg_ref_ext);
    wr(`ADCC_OFS_MODE0, 8'h01);
    wr(`ADCC_OFS_MODE2, 8'h40);
    rdc(`ADCC_OFS_STATUS, 32'h1);
    wr(`ADCC_OFS_STATUS, 8'h01);
    rdc(`ADCC_OFS_STATUS, 32'h0);
    wr(`ADCC_OFS_MODE2, 8'h00);
    // One conversion per divisor; last one repeats on its own
    for (i = 0; i < 4; i++)
    begin
      dv = dvf(divs[i]);
      up = (i == 1 || i == 2) ? 8'($random(seed)) : 8'hff;
      lo = (i == 1 || i == 2) ? 8'($random(seed)) : 8'h00;
      sample_data <= 10'($random(seed));
      wr(`ADCC_OFS_UPPER, up);
      wr(`ADCC_OFS_LOWER, lo);
      wr(`ADCC_OFS_MODE2, {4'h0, i == 1, 2'b00, i == 2});
      wr(`ADCC_OFS_MODE1, {2'b00, i != 3, 5'h0});
      wr(`ADCC_OFS_IMASK, {7'h7f, i[0]});
      wr(`ADCC_OFS_IFLAG, 8'h00);
      m0 = {2'b10, divs[i], 3'b001};
      wr(`ADCC_OFS_MODE0, m0);
      rdc(`ADCC_OFS_MODE0, {24'h0, m0});
      for (n = 0; n < 3000 && !sample_strobe; n++) @(posedge clk);
      if (n == 3000) tmo;
      chk("conv_len", 1, n >= 22 * dv - 12 && n <= 23 * dv + 8);
      repeat (3) @(posedge clk);
      f = flag_of(sample_data, up, lo, i == 1);
      rdc(`ADCC_OFS_RESULT, (i == 2) ? {16'h0, sample_data[9:2], 8'h0}
                                     : {16'h0, sample_data, 6'h0});
      rdc(`ADCC_OFS_IFLAG, {31'h0, f});
      chk("irq", f && !i[0], conversion_end_irq);
      lim = 23 * dv + 8;
      for (n = 0; n < lim; n++)
      begin
        @(posedge clk);
        if (sample_strobe) break;
      end
      chk("repeat", i == 3, n < lim);
      wr(`ADCC_OFS_MODE0, 8'h00);
      repeat (lim) @(posedge clk);
    end
    // Hardware trigger, no-wait then wait: one conversion per pin edge
    for (i = 0; i < 2; i++)
    begin
      wr(`ADCC_OFS_MODE1, {1'b1, i[0], 6'h00});
      wr(`ADCC_OFS_MODE0, 8'ha1);
      for (n = 0; n < 200; n++)
      begin
        @(posedge clk);
        if (sample_strobe) break;
      end
      chk("hw_idle", 200, n);
      hw_trigger <= 1;
      for (n = 0; n < 3000 && !sample_strobe; n++) @(posedge clk);
      if (n == 3000) tmo;
      lim = (22 + 4 * i) * 6;
      chk("hw_len", 1, n >= lim && n <= lim + 14);
      for (n = 0; n < 200; n++)
      begin
        @(posedge clk);
        if (sample_strobe) break;
      end
      chk("hw_once", 200, n);
      hw_trigger <= 0;
      wr(`ADCC_OFS_MODE0, 8'h00);
    end
    // Reset in mid-conversion stops it and restores the reset values
    wr(`ADCC_OFS_UPPER, 8'h5a);
    wr(`ADCC_OFS_MODE1, 8'h00);
    wr(`ADCC_OFS_MODE0, 8'h81);
    repeat (50) @(posedge clk);
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    chk("rst_irq", 0, conversion_end_irq);
    rdc(`ADCC_OFS_MODE0, 32'h0);
    rdc(`ADCC_OFS_UPPER, 32'hff);
    for (n = 0; n < 1000 && !sample_strobe; n++) @(posedge clk);
    chk("rst_stop", 1000, n);
    finish_test;
  end
endmodule // adcc_top_tb

bind adcc_top adcc_properties chk_u (.*);
